// ### include/uef_pkg.sv
/*
 * Package for the USB error flag and descriptor base block: register
 * indices, flag bit positions, reset values, timing counts and carriers.
 * Assumes a single 20 MHz system clock and a plain register port.
 */
package uef_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_ERROR_FLAGS   = 8'h00;
    localparam logic [7:0] ADDR_ERROR_MASK    = 8'h04;
    localparam logic [7:0] ADDR_BASE_MID      = 8'h08;
    localparam logic [7:0] ADDR_BASE_TOP      = 8'h0C;
    localparam logic [7:0] ADDR_BT_LIMIT      = 8'h10;

    // ------------------------------------------------------------------
    // Flag bit positions
    // ------------------------------------------------------------------
    localparam int BIT_STUFF     = 7;
    localparam int BIT_BUS_MATRIX = 6;
    localparam int BIT_DMA       = 5;
    localparam int BIT_TURNAROUND = 4;
    localparam int BIT_FIELD_SIZE = 3;
    localparam int BIT_DATA_CRC  = 2;
    localparam int BIT_SOF_LATE  = 1;
    localparam int FLAG_W        = 8;

    // ------------------------------------------------------------------
    // Reset values and layout
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_FLAGS    = 8'h00;
    localparam logic [7:0] RST_MASK     = 8'h00;
    localparam logic [7:0] RST_BASE_MID = 8'h00;
    localparam logic [7:0] RST_BASE_TOP = 8'h00;
    localparam logic [15:0] BASE_LOW_ZERO = 16'h0000;
    localparam int          BASE_ALIGN_BITS = 9;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int TURNAROUND_BIT_TIMES = 16;
    localparam logic [7:0] RST_BIT_TICKS = 8'h01;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic stuff_err;
        logic addr_err;
        logic dma_late;
        logic dma_trunc;
        logic field_frac;
        logic crc16_bad;
        logic sof_zero;
        logic busy;
    } uef_events_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } uef_bus_req_t;

endpackage : uef_pkg

// ### design/uef_top.sv
/*
 * USB error flag register, descriptor table base registers and the bus
 * turnaround timer. Assumes the packet engine reports events as one-cycle
 * pulses synchronous to clk_sys and a bit-time enable pulse.
 */
// The placing of the registers and the strobed register port were left to the implementer.
// Summary of operation
// - Bit stuffing error on a received packet sets flag bit 7.
// - Invalid table base or buffer address sets flag bit 6.
// - A DMA error during packet transfer sets flag bit 5.
// - DMA error is a late bus grant or a truncated received packet.
// - A missing response within the turnaround window sets flag bit 4.
// - Timeout fires after more than sixteen idle bit times since EOP.
// - A data field of fractional byte length sets flag bit 3.
// - A data packet with bad CRC16 is rejected and sets bit 2.
// - Busy transfer when the frame counter reaches zero sets a flag.
// - Hardware sets flags; software clears one by writing a one.
// - Error flag bits 31 to 8 always read as zero.
// - An 8-bit register supplies table base address bits 23 to 16.
// - A second 8-bit register supplies table base bits 31 to 24.
// - Table base is 512-byte aligned; hardware holds its low 16 bits at zero.
`timescale 1ns/1ps

module uef_top (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    // Register port
    input  wire uef_pkg::uef_bus_req_t bus_req,
    output logic [31:0]               rd_data,
    // Packet engine events
    input  wire uef_pkg::uef_events_t ev,
    input  wire logic                 bit_tick,
    input  wire logic                 eop_seen,
    input  wire logic                 resp_wait,
    input  wire logic                 resp_start,
    // Outputs to the engine and DMA
    output logic [31:0]               table_base,
    output logic                      packet_reject,
    output logic                      irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]  flags;
    logic [7:0]  mask;
    logic [7:0]  base_mid;
    logic [7:0]  base_top;
    logic [4:0]  idle_bits;
    logic        waiting;
    logic        bt_fire;
    logic [7:0]  set_vec;
    logic [7:0]  clr_vec;
    logic [7:0]  next_flags;
    logic        wr_flags;

    // ------------------------------------------------------------------
    // Event mapping
    // ------------------------------------------------------------------
    always_comb begin
        set_vec = '0;
        set_vec[uef_pkg::BIT_STUFF] = ev.stuff_err;
        set_vec[uef_pkg::BIT_BUS_MATRIX] = ev.addr_err;
        set_vec[uef_pkg::BIT_DMA] = ev.dma_late | ev.dma_trunc;
        set_vec[uef_pkg::BIT_TURNAROUND] = bt_fire;
        set_vec[uef_pkg::BIT_FIELD_SIZE] = ev.field_frac;
        set_vec[uef_pkg::BIT_DATA_CRC] = ev.crc16_bad;
        set_vec[uef_pkg::BIT_SOF_LATE] = ev.sof_zero & ev.busy;
    end

    // ------------------------------------------------------------------
    // Turnaround timer
    // ------------------------------------------------------------------
    // Counts idle bit times after an end of packet while a reply is due.
    // more than sixteen bit times
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            idle_bits <= '0;
            waiting   <= 1'b0;
            bt_fire   <= 1'b0;
        end else begin
            bt_fire <= 1'b0;
            if (eop_seen && resp_wait) begin
                idle_bits <= '0;
                waiting   <= 1'b1;
            end else if (resp_start || !resp_wait) begin
                waiting <= 1'b0;
            end else if (waiting && bit_tick) begin
                if (idle_bits == 5'(uef_pkg::TURNAROUND_BIT_TIMES)) begin
                    bt_fire <= 1'b1;
                    waiting <= 1'b0;
                end else begin
                    idle_bits <= idle_bits + 5'd1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Error flags
    // ------------------------------------------------------------------
    assign wr_flags = bus_req.wr && bus_req.addr == uef_pkg::ADDR_ERROR_FLAGS;
    // write one to clear, zero keeps
    assign clr_vec = wr_flags ? bus_req.wdata[7:0] : 8'h00;
    // A set in the same cycle as its clear wins, so no event is lost.
    assign next_flags = (flags & ~clr_vec) | set_vec;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flags <= uef_pkg::RST_FLAGS;
        end else begin
            flags <= next_flags;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mask     <= uef_pkg::RST_MASK;
            base_mid <= uef_pkg::RST_BASE_MID;
            base_top <= uef_pkg::RST_BASE_TOP;
        end else if (bus_req.wr) begin
            unique case (bus_req.addr)
                uef_pkg::ADDR_ERROR_MASK: begin
                    mask <= bus_req.wdata[7:0];
                end
                uef_pkg::ADDR_BASE_MID: begin
                    base_mid <= bus_req.wdata[7:0];
                end
                uef_pkg::ADDR_BASE_TOP: begin
                    base_top <= bus_req.wdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Only the top two bytes are held here; the low half is zero, which
    // keeps the base on the alignment boundary whatever software writes.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            table_base    <= '0;
            packet_reject <= 1'b0;
            irq           <= 1'b0;
        end else begin
            table_base    <= {base_top, base_mid, uef_pkg::BASE_LOW_ZERO};
            packet_reject <= ev.crc16_bad | ev.stuff_err;
            irq           <= |(next_flags & mask);
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                uef_pkg::ADDR_ERROR_FLAGS: rd_data <= {24'h00_0000, flags};
                uef_pkg::ADDR_ERROR_MASK:  rd_data <= {24'h00_0000, mask};
                uef_pkg::ADDR_BASE_MID:    rd_data <= {24'h00_0000, base_mid};
                uef_pkg::ADDR_BASE_TOP:    rd_data <= {24'h00_0000, base_top};
                default:                   rd_data <= '0;
            endcase
        end else begin
            rd_data <= '0;
        end
    end

endmodule : uef_top

// ### testbench/uef_top_asserts.sv
/* Port assertions for the error flag block.
   Assumes the one-cycle read and event timing of the block. */
`timescale 1ns/1ps
module uef_top_asserts (
    // Clock, reset and register port
    input wire logic                  clk_sys,
    input wire logic                  arst_n,
    input wire uef_pkg::uef_bus_req_t bus_req,
    input wire logic [31:0]           rd_data,
    // Events and outputs
    input wire uef_pkg::uef_events_t  ev,
    input wire logic [31:0]           table_base,
    input wire logic                  packet_reject,
    input wire logic                  irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_crc_reject: assert property (ev.crc16_bad |=> packet_reject)
        else $error("reject missing after crc error");
    a_stuff_reject: assert property (ev.stuff_err |=> packet_reject)
        else $error("reject missing after stuff error");
    a_reject_cause: assert property (
        packet_reject |-> $past(ev.crc16_bad || ev.stuff_err))
        else $error("reject without cause");
    a_rd_upper: assert property (
        $past(bus_req.rd) |-> rd_data[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_rd_quiet: assert property (!$past(bus_req.rd) |-> rd_data == 0)
        else $error("read data outside read cycle");
    a_base_mid: assert property (
        bus_req.wr && bus_req.addr == uef_pkg::ADDR_BASE_MID
        |-> ##2 table_base[23:16] == $past(bus_req.wdata[7:0], 2))
        else $error("mid base byte not taken");
    a_base_top: assert property (
        bus_req.wr && bus_req.addr == uef_pkg::ADDR_BASE_TOP
        |-> ##2 table_base[31:24] == $past(bus_req.wdata[7:0], 2))
        else $error("top base byte not taken");
    a_base_align: assert property (table_base[8:0] == 9'h000)
        else $error("table base not aligned");
    a_flag_sticky: assert property (ev.crc16_bad ##1 !bus_req.wr ##1
        (bus_req.rd && bus_req.addr == uef_pkg::ADDR_ERROR_FLAGS)
        |=> rd_data[uef_pkg::BIT_DATA_CRC])
        else $error("crc flag not read back");
    c_irq: cover property (irq);
    c_reject: cover property (packet_reject);
    c_base: cover property ($rose(table_base[29]));
endmodule : uef_top_asserts

bind uef_top uef_top_asserts u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .bus_req(bus_req), .rd_data(rd_data), .ev(ev), .table_base(table_base),
    .packet_reject(packet_reject), .irq(irq));

// ### testbench/uef_peer.sv
/* Behavioural bus peer: end of packet, response wait and bit ticks.
   Assumes the bench calls turn from its main sequence only. */
`timescale 1ns/1ps
module uef_peer (
    // Clock
    input wire logic clk_sys,
    // Bus timing towards the block
    output logic     bit_tick,
    output logic     eop_seen,
    output logic     resp_wait,
    output logic     resp_start
);
    initial {bit_tick, eop_seen, resp_wait, resp_start} = 4'h0;
    task turn(input int n, input bit ans);
        @(posedge clk_sys) {eop_seen, resp_wait} <= 2'b11;
        @(posedge clk_sys) eop_seen <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys) {bit_tick, resp_start} <= 2'b10;
            @(posedge clk_sys) {bit_tick, resp_start} <= {1'b0, ans && i == 8};
        end
        @(posedge clk_sys) {resp_wait, resp_start} <= 2'b00;
    endtask : turn
endmodule : uef_peer

// ### testbench/tb_uef_top.sv
/* Self-checking bench for the error flag block.
   Assumes the block and the peer share clk_sys. */
`timescale 1ns/1ps
module tb_uef_top;
    logic                  clk_sys = 1'b0;
    logic                  arst_n  = 1'b0;
    uef_pkg::uef_bus_req_t bus_req = '0;
    uef_pkg::uef_events_t  ev      = '0;
    logic [31:0]           rd_data, table_base;
    logic                  bit_tick, eop_seen, resp_wait, resp_start;
    logic                  packet_reject, irq;
    int                    mismatches = 0, n_tests = 0, cycles = 0;
    logic [7:0] evs [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
                            8'h03, 8'h02};
    logic [7:0] flg [8] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h08, 8'h04,
                            8'h02, 8'h00};
    always #25 clk_sys = ~clk_sys;
    uef_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req),
        .rd_data(rd_data), .ev(ev), .bit_tick(bit_tick),
        .eop_seen(eop_seen), .resp_wait(resp_wait), .resp_start(resp_start),
        .table_base(table_base), .packet_reject(packet_reject), .irq(irq));
    uef_peer u_peer (.clk_sys(clk_sys), .bit_tick(bit_tick),
        .eop_seen(eop_seen), .resp_wait(resp_wait), .resp_start(resp_start));
    task check(input string n, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys) bus_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys) bus_req <= '0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge clk_sys) bus_req <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clk_sys) bus_req <= '0;
        #1 check(n, e, rd_data);
    endtask : rd
    task pulse(input logic [7:0] v);
        @(posedge clk_sys) ev <= v;
        @(posedge clk_sys) ev <= '0;
        #1;
    endtask : pulse
    task final_report;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    // A hang counts as a mismatch.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(8'h00, 32'h0, "flags");
        rd(8'h04, 32'h0, "mask");
        rd(8'h0C, 32'h0, "top");
        wr(8'h08, 32'hFFFF_FFA5);
        wr(8'h0C, 32'h1234_563C);
        rd(8'h08, 32'h0000_00A5, "mid");
        rd(8'h0C, 32'h0000_003C, "top");
        check("base", 32'h3CA5_0000, table_base);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0, "unmapped");
        for (int k = 0; k < 8; k++) begin
            pulse(evs[k]);
            check("reject", k == 0 || k == 5, packet_reject);
            rd(8'h00, flg[k], "flags");
            wr(8'h00, 32'hFFFF_FF00);
            rd(8'h00, flg[k], "sticky");
            wr(8'h00, flg[k]);
            rd(8'h00, 32'h0, "cleared");
        end
        wr(8'h04, 32'h4);
        pulse(8'h04);
        check("irq", 32'h1, irq);
        wr(8'h04, 32'h0);
        repeat (2) @(posedge clk_sys);
        #1 check("irq", 32'h0, irq);
        wr(8'h00, 32'h4);
        wr(8'h04, 32'h4);
        repeat (2) @(posedge clk_sys);
        #1 check("irq", 32'h0, irq);
        u_peer.turn(16, 1'b0);
        rd(8'h00, 32'h0, "turn16");
        u_peer.turn(17, 1'b0);
        rd(8'h00, 32'h10, "turn17");
        wr(8'h00, 32'h10);
        u_peer.turn(20, 1'b1);
        rd(8'h00, 32'h0, "answered");
        final_report();
    end
endmodule : tb_uef_top
